//--- src/demod_setup_pkg.sv
/*
 Constants shared by the demodulator setup and reset control block:
 register indices, field positions, reset values and timing counts.
 Assumes the registers are reached by 7-bit index over the 2-wire port.
*/
package demod_setup_pkg;

	// register indices
	localparam logic [6:0] REG_BLOCK_RESET = 7'h15;
	localparam logic [6:0] REG_SYMBOL_RATE_REGS_HI = 7'h17;
	localparam logic [6:0] REG_SYMBOL_RATE_REGS_LO = 7'h18;
	localparam logic [6:0] REG_DECODER_MODE = 7'h19;
	localparam logic [6:0] REG_DEMOD_CONTROL = 7'h1A;
	localparam logic [6:0] REG_GO_CONTROL = 7'h1B;
	localparam logic [6:0] REG_SYS_FREQ_OVERRIDE = 7'h22;
	localparam logic [6:0] REG_NOISE_HIGH = 7'h31;
	localparam logic [6:0] REG_SWEEP_RATE = 7'h32;
	localparam logic [6:0] REG_DECODER_SETUP = 7'h56;
	localparam logic [6:0] REG_DEVICE_SETUP = 7'h7F;

	// device_setup fields
	localparam int SETUP_ENABLE_BIT = 7;
	localparam int FORMAT_MSB = 6;
	localparam int FORMAT_LSB = 5;
	localparam int MODULATION_BIT = 4;
	localparam int MULT_MSB = 3;
	localparam int MULT_LSB = 2;
	localparam int CRYSTAL_BIT = 1;
	localparam int CONVERTER_BIT = 0;

	// other control fields
	localparam int IQ_SWAP_BIT = 6;
	localparam int FILTER_OPTION_BIT = 0;
	localparam int TX_INV_BIT = 6;
	localparam int AUTO_INV_BIT = 7;
	localparam int CODE_RATE_MSB = 5;
	localparam int GO_BIT = 0;
	localparam int NO_INCREMENT_BIT = 7;

	// block_reset_control bits
	localparam int RST_FULL_DEVICE = 7;
	localparam int RST_PARTIAL_DEVICE = 6;
	localparam int RST_FULL_DEMOD = 5;
	localparam int RST_PARTIAL_DEMOD = 4;
	localparam int RST_FULL_DECODER = 3;
	localparam int RST_PARTIAL_DECODER = 2;
	localparam int RST_PARTIAL_ALIGN = 1;
	localparam int RST_PARTIAL_DESCRAMBLER = 0;
	localparam logic [7:0] FULL_DEVICE_FANOUT = 8'h2B;

	// reset values
	localparam logic [7:0] SETUP_DEFAULT = 8'h00;
	localparam logic [7:0] REG8_DEFAULT = 8'h00;
	localparam logic [15:0] SYMBOL_RATE_REGS_DEFAULT = 16'h0000;

	// broadcast formats and forced parameters
	typedef enum logic [1:0] {
		FMT_OPEN = 2'h0,
		FMT_ALT_RATE_2_3 = 2'h1,
		FMT_ALT_RATE_6_7 = 2'h2,
		FMT_ALT_SEARCH = 2'h3
	} broadcast_format_t;
	localparam logic [15:0] ALT_SYMBOL_RATE = 16'h0014;
	localparam logic [5:0] CODE_RATE_2_3 = 6'h02;
	localparam logic [5:0] CODE_RATE_6_7 = 6'h10;
	localparam logic [5:0] CODE_RATE_ALT_SEARCH = 6'h12;

	// clock multiplier and crystal values
	localparam logic [3:0] MULT_FACTOR_0 = 4'h3;
	localparam logic [3:0] MULT_FACTOR_1 = 4'h4;
	localparam logic [3:0] MULT_FACTOR_2 = 4'h6;
	localparam logic [3:0] MULT_FACTOR_3 = 4'h9;
	localparam logic [3:0] XTAL_LOW_MHZ = 4'hA;
	localparam logic [3:0] XTAL_HIGH_MHZ = 4'hF;

	// reset pulse length in crystal periods (core_clk runs from the crystal)
	localparam int PULSE_CYCLES = 3;

endpackage

//--- src/reset_pulse_gen.sv
/*
 Reset pulse generator: issues the requested reset bits together as one
 pulse of fixed length and reports completion with a one-cycle done.
 Assumes core_clk is the crystal clock and the request stays up until done.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_pulse_gen
	import demod_setup_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int CYCLES = PULSE_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] request,
	output logic [WIDTH-1:0] pulse,
	output logic busy,
	output logic done
);

	logic [3:0] count;
	logic startPulse;

	assign startPulse = !busy && !done && (|request);

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			pulse <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			count <= 4'h0;
		end
		else if (startPulse)
		begin
			pulse <= request;
			busy <= 1'b1;
			done <= 1'b0;
			count <= 4'(CYCLES - 1);
		end
		else if (busy && count == 4'h0)
		begin
			pulse <= '0;
			busy <= 1'b0;
			done <= 1'b1;
		end
		else
		begin
			count <= busy ? count - 4'h1 : count;
			done <= 1'b0;
		end
	end

	sequence s_pulse_held;
		(|pulse)[*3] ##1 !(|pulse);
	endsequence

	a_pulse_width: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(|pulse) |-> s_pulse_held)
		else $error("reset pulse not three cycles wide");

	a_done_after_pulse: assert property (@(posedge core_clk)
		disable iff (!rst_b) $fell(|pulse) |-> done ##1 !done)
		else $error("done not a single pulse after reset pulse");

endmodule
`default_nettype wire

//--- src/sys_freq_select.sv
/*
 System frequency select: works out twice the system clock in MHz from
 the multiplier and crystal selects, or takes the override when non-zero.
 Assumes its inputs come from registers in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sys_freq_select
	import demod_setup_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [1:0] multCode,
	input wire logic crystalHigh,
	input wire logic [7:0] override,
	output logic [8:0] sysFreqX2,
	output logic usingOverride
);

	function automatic logic [3:0] multFactor(input logic [1:0] code);
		unique case (code)
			2'h0: multFactor = MULT_FACTOR_0;
			2'h1: multFactor = MULT_FACTOR_1;
			2'h2: multFactor = MULT_FACTOR_2;
			2'h3: multFactor = MULT_FACTOR_3;
		endcase
	endfunction

	logic [3:0] xtalMhz;
	logic [8:0] derivedX2;
	logic overrideActive;

	assign xtalMhz = crystalHigh ? XTAL_HIGH_MHZ : XTAL_LOW_MHZ;
	// operands widened first so the product cannot wrap
	assign derivedX2 = {4'h0, multFactor(multCode), 1'b0}
		* {5'h00, xtalMhz};
	assign overrideActive = |override;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			sysFreqX2 <= 9'h000;
			usingOverride <= 1'b0;
		end
		else
		begin
			sysFreqX2 <= overrideActive ? {1'b0, override} : derivedX2;
			usingOverride <= overrideActive;
		end
	end

	a_override_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
		override != 8'h00 |=> sysFreqX2 == {1'b0, $past(override)})
		else $error("override not used as system frequency");

	a_derived_freq: assert property (@(posedge core_clk) disable iff (!rst_b)
		(override == 8'h00 && multCode == 2'h2 && !crystalHigh)
		|=> sysFreqX2 == 9'h078)
		else $error("derived system frequency wrong");

endmodule
`default_nettype wire

//--- src/demod_setup_reset.sv
/*
 Setup and reset control for the demodulator and decoder: 2-wire register
 slave, device setup register, self-clearing block reset register, system
 frequency override and the derived control outputs.
 Assumes scl and sda inputs are synchronous to core_clk and slow enough
 that each bus phase spans several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - full reset restores all but setup register
// - writing 128 to reset register resets all but setup register
// - go bit releases acquisition state machine
// - setup bit 7 enables, low means power save
// - setup bits 6-5 pick broadcast format
// - alternate format forces rate, rolloff, code rates
// - setup bit 4 picks bpsk or qpsk
// - system frequency from multiplier and crystal
// - setup bit 0 picks external converter
// - nonzero override replaces derived system frequency
// - reset register bits map to sub-block resets
// - each reset pulse lasts three crystal periods
// - reset register clears itself after pulse
// - full reset restores registers, partial does not
// - iq swap bit exchanges i and q
// - decoder mode bits set or detect inversion
module demod_setup_reset
	import demod_setup_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = 7'h0E, // arbitrary value
	parameter int SAMPLE_WIDTH = 8
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [SAMPLE_WIDTH-1:0] iIn,
	input wire logic [SAMPLE_WIDTH-1:0] qIn,
	output logic [SAMPLE_WIDTH-1:0] iOut,
	output logic [SAMPLE_WIDTH-1:0] qOut,
	output logic deviceEnabled,
	output logic powerSave,
	output logic [1:0] broadcastFormat,
	output logic bpskSelect,
	output logic externalConverterSel,
	output logic [8:0] sysFreqX2,
	output logic forcedSymbolRate,
	output logic rollOff20,
	output logic [15:0] effSymbolRate,
	output logic filterOption,
	output logic [5:0] codeRateMask,
	output logic frontendIqSwap,
	output logic txSpectrumInverted,
	output logic autoInversionDetect,
	output logic [7:0] noiseHighThreshold,
	output logic [7:0] timingSweepRate,
	output logic acquisitionRun,
	output logic fullDeviceReset,
	output logic partialDeviceReset,
	output logic fullDemodReset,
	output logic partialDemodReset,
	output logic fullDecoderReset,
	output logic partialDecoderReset,
	output logic partialAlignReset,
	output logic partialDescramblerReset
);

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_INDEX = 5'h04,
		ST_WRITE = 5'h08,
		ST_READ = 5'h10
	} link_state_t;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// registers
	logic [7:0] deviceSetup;
	logic [7:0] blockResetControl;
	logic [7:0] sysFreqOverride;
	logic [15:0] symbolRate;
	logic [7:0] decoderMode;
	logic [7:0] demodControl;
	logic [7:0] goControl;
	logic [7:0] noiseHigh;
	logic [7:0] sweepRate;
	logic [7:0] decoderSetup;

	// link state
	link_state_t linkState;
	logic sclPrev;
	logic sdaPrev;
	logic [3:0] bitCnt;
	logic [7:0] rxShift;
	logic [7:0] txShift;
	logic ackPhase;
	logic [6:0] regIndex;
	logic noIncrement;
	logic writeStrobe;
	logic [6:0] wIndex;
	logic [7:0] wData;

	function automatic logic [7:0] readBack(input logic [6:0] idx,
		input logic [7:0] setupV, input logic [7:0] resetV,
		input logic [7:0] overV, input logic [15:0] symV,
		input logic [7:0] modeV, input logic [7:0] ctrlV,
		input logic [7:0] goV, input logic [7:0] noiseV,
		input logic [7:0] sweepV, input logic [7:0] setV);
		unique case (idx)
			REG_DEVICE_SETUP: readBack = setupV;
			REG_BLOCK_RESET: readBack = resetV;
			REG_SYS_FREQ_OVERRIDE: readBack = overV;
			REG_SYMBOL_RATE_REGS_HI: readBack = symV[15:8];
			REG_SYMBOL_RATE_REGS_LO: readBack = symV[7:0];
			REG_DECODER_MODE: readBack = modeV;
			REG_DEMOD_CONTROL: readBack = ctrlV;
			REG_GO_CONTROL: readBack = goV;
			REG_NOISE_HIGH: readBack = noiseV;
			REG_SWEEP_RATE: readBack = sweepV;
			REG_DECODER_SETUP: readBack = setV;
			default: readBack = 8'h00;
		endcase
	endfunction

	// bus conditions
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic addrMatch;
	logic [7:0] readData;
	logic [6:0] nextIndex;

	assign sclRise = sclIn && !sclPrev;
	assign sclFall = !sclIn && sclPrev;
	assign startCond = sclIn && sclPrev && sdaPrev && !sdaIn;
	assign stopCond = sclIn && sclPrev && !sdaPrev && sdaIn;
	assign addrMatch = rxShift[7:1] == DEVICE_ADDR;
	assign nextIndex = noIncrement ? regIndex : regIndex + 7'h01;
	assign readData = readBack(regIndex, deviceSetup, blockResetControl,
		sysFreqOverride, symbolRate, decoderMode, demodControl, goControl,
		noiseHigh, sweepRate, decoderSetup);

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclPrev <= sclIn;
			sdaPrev <= sdaIn;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b || stopCond)
		begin
			linkState <= ST_IDLE;
			bitCnt <= 4'h0;
			ackPhase <= 1'b0;
			sdaOe <= 1'b0;
			writeStrobe <= 1'b0;
		end
		else if (startCond)
		begin
			linkState <= ST_ADDR;
			bitCnt <= 4'h0;
			ackPhase <= 1'b0;
			sdaOe <= 1'b0;
			writeStrobe <= 1'b0;
		end
		else
		begin
			writeStrobe <= 1'b0;
			if (sclRise && !ackPhase && linkState != ST_READ
				&& linkState != ST_IDLE && bitCnt < 4'h8)
			begin
				rxShift <= {rxShift[6:0], sdaIn};
				bitCnt <= bitCnt + 4'h1;
			end
			else if (sclRise && linkState == ST_READ && bitCnt == 4'h9)
			begin
				if (sdaIn)
					linkState <= ST_IDLE;
				else
				begin
					ackPhase <= 1'b1;
					regIndex <= nextIndex;
				end
			end
			else if (sclFall && ackPhase)
			begin
				ackPhase <= 1'b0;
				if (linkState == ST_READ)
				begin
					txShift <= {readData[6:0], 1'b0};
					sdaOe <= !readData[7];
					bitCnt <= 4'h1;
				end
				else
				begin
					sdaOe <= 1'b0;
					bitCnt <= 4'h0;
				end
			end
			else if (sclFall && linkState == ST_READ)
			begin
				sdaOe <= bitCnt < 4'h8 ? !txShift[7] : 1'b0;
				txShift <= {txShift[6:0], 1'b0};
				bitCnt <= bitCnt < 4'h8 ? bitCnt + 4'h1 : 4'h9;
			end
			else if (sclFall && bitCnt == 4'h8)
			begin
				unique case (linkState)
					ST_ADDR:
					begin
						ackPhase <= addrMatch;
						sdaOe <= addrMatch;
						linkState <= !addrMatch ? ST_IDLE
							: (rxShift[0] ? ST_READ : ST_INDEX);
					end
					ST_INDEX:
					begin
						regIndex <= rxShift[6:0];
						noIncrement <= rxShift[NO_INCREMENT_BIT];
						ackPhase <= 1'b1;
						sdaOe <= 1'b1;
						linkState <= ST_WRITE;
					end
					ST_WRITE:
					begin
						writeStrobe <= 1'b1;
						wIndex <= regIndex;
						wData <= rxShift;
						regIndex <= nextIndex;
						ackPhase <= 1'b1;
						sdaOe <= 1'b1;
					end
					default: linkState <= ST_IDLE;
				endcase
			end
		end
	end

	// write decode
	logic [7:0] resetPulse;
	logic pulseBusy;
	logic pulseDone;
	logic wrSetup;
	logic wrBlockReset;
	logic wrOverride;
	logic wrGo;
	logic restoreAll;
	logic restoreDemod;
	logic restoreDecoder;
	logic deviceLogicReset;
	logic altFormat;
	logic [7:0] resetRequest;
	logic [5:0] nextCodeRateMask;

	assign wrSetup = writeStrobe && wIndex == REG_DEVICE_SETUP;
	assign wrBlockReset = writeStrobe && wIndex == REG_BLOCK_RESET
		&& !pulseBusy && !pulseDone;
	assign wrOverride = writeStrobe && wIndex == REG_SYS_FREQ_OVERRIDE;
	assign wrGo = writeStrobe && wIndex == REG_GO_CONTROL;
	assign restoreAll = resetPulse[RST_FULL_DEVICE];
	assign restoreDemod = resetPulse[RST_FULL_DEMOD];
	assign restoreDecoder = resetPulse[RST_FULL_DECODER];
	assign deviceLogicReset = resetPulse[RST_FULL_DEVICE]
		|| resetPulse[RST_PARTIAL_DEVICE];
	assign resetRequest = blockResetControl[RST_FULL_DEVICE]
		? (blockResetControl | FULL_DEVICE_FANOUT) : blockResetControl;
	assign altFormat = |deviceSetup[FORMAT_MSB:FORMAT_LSB];

	always_comb
	begin
		unique case (broadcast_format_t'(deviceSetup[FORMAT_MSB:FORMAT_LSB]))
			FMT_OPEN: nextCodeRateMask = decoderMode[CODE_RATE_MSB:0];
			FMT_ALT_RATE_2_3: nextCodeRateMask = CODE_RATE_2_3;
			FMT_ALT_RATE_6_7: nextCodeRateMask = CODE_RATE_6_7;
			FMT_ALT_SEARCH: nextCodeRateMask = CODE_RATE_ALT_SEARCH;
		endcase
	end

	// setup register only follows the hardware reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			deviceSetup <= SETUP_DEFAULT;
		else if (wrSetup)
			deviceSetup <= wData;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b || restoreAll)
		begin
			blockResetControl <= REG8_DEFAULT;
			sysFreqOverride <= REG8_DEFAULT;
			symbolRate <= SYMBOL_RATE_REGS_DEFAULT;
			decoderMode <= REG8_DEFAULT;
			demodControl <= REG8_DEFAULT;
			goControl <= REG8_DEFAULT;
			noiseHigh <= REG8_DEFAULT;
			sweepRate <= REG8_DEFAULT;
			decoderSetup <= REG8_DEFAULT;
		end
		else
		begin
			if (pulseDone)
				blockResetControl <= REG8_DEFAULT;
			else if (wrBlockReset)
				blockResetControl <= wData;
			if (wrOverride)
				sysFreqOverride <= wData;
			if (wrGo)
				goControl <= wData;
			if (writeStrobe && wIndex == REG_NOISE_HIGH)
				noiseHigh <= wData;
			if (writeStrobe && wIndex == REG_SWEEP_RATE)
				sweepRate <= wData;
			if (restoreDemod)
			begin
				symbolRate <= SYMBOL_RATE_REGS_DEFAULT;
				demodControl <= REG8_DEFAULT;
			end
			else
			begin
				if (writeStrobe && wIndex == REG_SYMBOL_RATE_REGS_HI)
					symbolRate[15:8] <= wData;
				if (writeStrobe && wIndex == REG_SYMBOL_RATE_REGS_LO)
					symbolRate[7:0] <= wData;
				if (writeStrobe && wIndex == REG_DEMOD_CONTROL)
					demodControl <= wData;
			end
			if (restoreDecoder)
			begin
				decoderMode <= REG8_DEFAULT;
				decoderSetup <= REG8_DEFAULT;
			end
			else
			begin
				if (writeStrobe && wIndex == REG_DECODER_MODE)
					decoderMode <= wData;
				if (writeStrobe && wIndex == REG_DECODER_SETUP)
					decoderSetup <= wData;
			end
		end
	end

	// acquisition release; device resets and power save stop it
	always_ff @(posedge core_clk)
	begin
		if (!rst_b || deviceLogicReset || !deviceSetup[SETUP_ENABLE_BIT])
			acquisitionRun <= 1'b0;
		else if (wrGo && wData[GO_BIT])
			acquisitionRun <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			sdaOut <= 1'b0;
			deviceEnabled <= 1'b0;
			powerSave <= 1'b1;
			broadcastFormat <= FMT_OPEN;
			bpskSelect <= 1'b0;
			externalConverterSel <= 1'b0;
			forcedSymbolRate <= 1'b0;
			rollOff20 <= 1'b0;
			effSymbolRate <= SYMBOL_RATE_REGS_DEFAULT;
			filterOption <= 1'b0;
			codeRateMask <= 6'h00;
			frontendIqSwap <= 1'b0;
			txSpectrumInverted <= 1'b0;
			autoInversionDetect <= 1'b0;
			noiseHighThreshold <= REG8_DEFAULT;
			timingSweepRate <= REG8_DEFAULT;
			iOut <= '0;
			qOut <= '0;
		end
		else
		begin
			sdaOut <= 1'b0;
			deviceEnabled <= deviceSetup[SETUP_ENABLE_BIT];
			powerSave <= !deviceSetup[SETUP_ENABLE_BIT];
			broadcastFormat <= deviceSetup[FORMAT_MSB:FORMAT_LSB];
			bpskSelect <= deviceSetup[MODULATION_BIT];
			externalConverterSel <= deviceSetup[CONVERTER_BIT];
			forcedSymbolRate <= altFormat;
			rollOff20 <= altFormat;
			effSymbolRate <= altFormat ? ALT_SYMBOL_RATE : symbolRate;
			filterOption <= !altFormat && demodControl[FILTER_OPTION_BIT];
			codeRateMask <= nextCodeRateMask;
			frontendIqSwap <= demodControl[IQ_SWAP_BIT];
			txSpectrumInverted <= decoderMode[TX_INV_BIT];
			autoInversionDetect <= decoderMode[AUTO_INV_BIT];
			noiseHighThreshold <= noiseHigh;
			timingSweepRate <= sweepRate;
			if (!deviceSetup[SETUP_ENABLE_BIT])
			begin
				iOut <= '0;
				qOut <= '0;
			end
			else
			begin
				iOut <= demodControl[IQ_SWAP_BIT] ? qIn : iIn;
				qOut <= demodControl[IQ_SWAP_BIT] ? iIn : qIn;
			end
		end
	end

	reset_pulse_gen #(.WIDTH(8), .CYCLES(PULSE_CYCLES)) pulseGen (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.request(resetRequest),
		.pulse(resetPulse),
		.busy(pulseBusy),
		.done(pulseDone)
	);

	sys_freq_select freqSelect (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.multCode(deviceSetup[MULT_MSB:MULT_LSB]),
		.crystalHigh(deviceSetup[CRYSTAL_BIT]),
		.override(sysFreqOverride),
		.sysFreqX2(sysFreqX2),
		.usingOverride()
	);

	assign fullDeviceReset = resetPulse[RST_FULL_DEVICE];
	assign partialDeviceReset = resetPulse[RST_PARTIAL_DEVICE];
	assign fullDemodReset = resetPulse[RST_FULL_DEMOD];
	assign partialDemodReset = resetPulse[RST_PARTIAL_DEMOD];
	assign fullDecoderReset = resetPulse[RST_FULL_DECODER];
	assign partialDecoderReset = resetPulse[RST_PARTIAL_DECODER];
	assign partialAlignReset = resetPulse[RST_PARTIAL_ALIGN];
	assign partialDescramblerReset = resetPulse[RST_PARTIAL_DESCRAMBLER];

	a_setup_survives: assert property (
		fullDeviceReset && !wrSetup |=> $stable(deviceSetup))
		else $error("setup register changed by full reset");

	a_full_restore: assert property (
		fullDeviceReset |=> noiseHigh == REG8_DEFAULT
			&& sysFreqOverride == REG8_DEFAULT && goControl == REG8_DEFAULT)
		else $error("full reset did not restore defaults");

	a_reset_selfclear: assert property (
		$rose(|resetPulse) |-> ##4 blockResetControl == REG8_DEFAULT)
		else $error("reset register did not clear itself");

	a_fanout_all: assert property (
		fullDeviceReset |-> fullDemodReset && fullDecoderReset
			&& partialAlignReset && partialDescramblerReset)
		else $error("full device reset missed a sub-block");

	a_partial_keeps: assert property (
		partialDeviceReset && !fullDeviceReset && !writeStrobe
		|=> $stable(noiseHigh) && $stable(sysFreqOverride))
		else $error("partial reset changed registers");

	a_power_save: assert property (
		!deviceSetup[SETUP_ENABLE_BIT] |=> powerSave && !acquisitionRun)
		else $error("power save not entered");

	a_forced_rate: assert property (
		altFormat |=> forcedSymbolRate && effSymbolRate == ALT_SYMBOL_RATE)
		else $error("alternate format did not force symbol rate");

	a_iq_swap: assert property (
		deviceSetup[SETUP_ENABLE_BIT] && demodControl[IQ_SWAP_BIT]
		|=> iOut == $past(qIn) && qOut == $past(iIn))
		else $error("i and q not swapped");

	a_go_start: assert property (
		wrGo && wData[GO_BIT] && deviceSetup[SETUP_ENABLE_BIT]
		&& !deviceLogicReset |=> acquisitionRun)
		else $error("go did not release acquisition");

	a_format_rate: assert property (
		deviceSetup[FORMAT_MSB:FORMAT_LSB] == FMT_ALT_RATE_2_3
		|=> codeRateMask == CODE_RATE_2_3)
		else $error("format code rate not forced");

endmodule
`default_nettype wire

//--- dv/host_model.sv
/*
 Host processor model on the 2-wire register bus: start, address,
 index and data bytes, stop. Each bus phase spans four core clocks.
 Assumes sda has a pull-up and the device pulls it low through sdaOe.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model
#(
	parameter logic [6:0] ADDR = 7'h0E // arbitrary value
)
(
	input wire logic core_clk,
	input wire logic sdaOe,
	input wire logic sdaOut,
	output logic sclIn,
	output logic sdaIn
);
	logic sdaDrv;
	// pulled-up wire: either party may pull it low
	assign sdaIn = sdaDrv & (sdaOe ? sdaOut : 1'b1);
	initial
	begin
		sclIn = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic step(input logic c, input logic d);
		@(posedge core_clk);
		#1;
		sclIn = c;
		sdaDrv = d;
		repeat (3) @(posedge core_clk);
	endtask
	// index bit7 low: auto-increment left on
	task automatic wr(input logic [6:0] idx, input logic [7:0] v);
		logic [26:0] b;
		b = {ADDR, 1'b0, 1'b1, 1'b0, idx, 1'b1, v, 1'b1};
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		for (int i = 26; i >= 0; i--)
		begin
			step(1'b0, b[i]);
			step(1'b1, b[i]);
		end
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		#1;
	endtask
	// shift bits out msb first, keeping the last eight seen on sda
	task automatic bits(input logic [17:0] b, input int n,
		output logic [7:0] got);
		for (int i = n - 1; i >= 0; i--)
		begin
			step(1'b0, b[i]);
			step(1'b1, b[i]);
			got = {got[6:0], sdaIn};
		end
	endtask
	// index frame, repeated start, one byte read, nack, stop
	task automatic rd(input logic [6:0] idx, output logic [7:0] v);
		logic [7:0] got;
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		bits({ADDR, 1'b0, 1'b1, 1'b0, idx, 1'b1}, 18, got);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		bits({1'b0, ADDR, 1'b1, 1'b1, 8'hFF}, 17, got);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		v = got;
		#1;
	endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
/*
 Self-checking bench for the setup and reset control block.
 Assumes the host model drives the bus; expectations come from functions.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import demod_setup_pkg::*;
	logic core_clk, rst_b, sclIn, sdaIn, sdaOut, sdaOe, deviceEnabled;
	logic powerSave, bpskSelect, externalConverterSel, forcedSymbolRate;
	logic rollOff20, filterOption, frontendIqSwap, txSpectrumInverted;
	logic autoInversionDetect, acquisitionRun, fullDeviceReset;
	logic partialDeviceReset, fullDemodReset, partialDemodReset;
	logic fullDecoderReset, partialDecoderReset, partialAlignReset;
	logic partialDescramblerReset;
	logic [7:0] iIn, qIn, iOut, qOut, noiseHighThreshold, timingSweepRate;
	logic [1:0] broadcastFormat;
	logic [8:0] sysFreqX2;
	logic [15:0] effSymbolRate;
	logic [5:0] codeRateMask;
	logic [7:0] rv, seen, s, v;
	logic [7:0] run[8];
	logic [7:0] lastLen[8];
	int error_cnt = 0;
	int samples_checked = 0;
	assign rv = {fullDeviceReset, partialDeviceReset, fullDemodReset,
		partialDemodReset, fullDecoderReset, partialDecoderReset,
		partialAlignReset, partialDescramblerReset};
	demod_setup_reset u_dut(.*);
	host_model u_host(.*);
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// pulse length monitor per reset output
	always @(posedge core_clk)
		for (int b = 0; b < 8; b++)
			if (rv[b] === 1'b1)
				run[b] = run[b] + 8'h01;
			else if (run[b] != 8'h00)
			begin
				lastLen[b] = run[b];
				seen[b] = 1'b1;
				run[b] = 8'h00;
			end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	function logic [8:0] fx2(input logic [7:0] c);
		int m;
		m = c[3:2] == 0 ? 3 : c[3:2] == 1 ? 4 : c[3:2] == 2 ? 6 : 9;
		return 9'(m * (c[1] ? 15 : 10) * 2);
	endfunction
	function logic [5:0] rate(input logic [1:0] f);
		return f == 0 ? 6'h00 : f == 1 ? 6'h02 : f == 2 ? 6'h10 : 6'h12;
	endfunction
	task end_of_test();
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#1000000;
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		rst_b = 1'b0;
		iIn = 8'h00;
		qIn = 8'h00;
		seen = 8'h00;
		for (int b = 0; b < 8; b++)
		begin
			run[b] = 8'h00;
			lastLen[b] = 8'h00;
		end
		void'($urandom(13895));
		tick(16);
		rst_b = 1'b1;
		tick(1);
		chk(16'(powerSave), 16'h0001);
		for (int i = 0; i < 6; i++)
		begin
			s = i == 5 ? 8'h88 : 8'($urandom);
			u_host.wr(REG_DEVICE_SETUP, s);
			tick(4);
			chk(16'(deviceEnabled), 16'(s[7]));
			chk(16'(powerSave), 16'(!s[7]));
			chk(16'(broadcastFormat), 16'(s[6:5]));
			chk(16'(forcedSymbolRate), 16'(s[6:5] != 0));
			chk(16'(rollOff20), 16'(s[6:5] != 0));
			chk(effSymbolRate, s[6:5] != 0 ? 16'h0014 : 16'h0000);
			chk(16'(codeRateMask), 16'(rate(s[6:5])));
			chk(16'(bpskSelect), 16'(s[4]));
			chk(16'(sysFreqX2), 16'(fx2(s)));
			chk(16'(externalConverterSel), 16'(s[0]));
		end
		v = 8'($urandom_range(182, 1));
		u_host.wr(REG_SYS_FREQ_OVERRIDE, v);
		tick(4);
		chk(16'(sysFreqX2), 16'(v));
		u_host.wr(REG_SYS_FREQ_OVERRIDE, 8'h00);
		tick(4);
		chk(16'(sysFreqX2), 16'(fx2(8'h88)));
		s = 8'($urandom);
		u_host.wr(REG_SYMBOL_RATE_REGS_HI, s);
		u_host.wr(REG_SYMBOL_RATE_REGS_LO, ~s);
		tick(4);
		chk(effSymbolRate, {s, ~s});
		u_host.wr(REG_DEMOD_CONTROL, 8'h41);
		u_host.wr(REG_DECODER_MODE, 8'hC0);
		iIn = 8'($urandom);
		qIn = 8'($urandom);
		tick(4);
		chk(16'(iOut), 16'(qIn));
		chk(16'(qOut), 16'(iIn));
		chk(16'({txSpectrumInverted, autoInversionDetect}), 16'h0003);
		chk(16'(filterOption), 16'h0001);
		chk(16'(frontendIqSwap), 16'h0001);
		tick(7500);
		u_host.wr(REG_NOISE_HIGH, 8'h32);
		u_host.wr(REG_SWEEP_RATE, 8'h14);
		u_host.wr(REG_GO_CONTROL, 8'h01);
		tick(4);
		chk(16'(acquisitionRun), 16'h0001);
		for (int b = 0; b < 7; b++)
		begin
			seen = 8'h00;
			u_host.wr(REG_BLOCK_RESET, 8'h01 << b);
			tick(8);
			chk(16'(seen), 16'(8'h01 << b));
			chk(16'(lastLen[b]), 16'h0003);
			chk(16'(noiseHighThreshold), 16'h0032);
		end
		seen = 8'h00;
		u_host.wr(REG_BLOCK_RESET, 8'h80);
		tick(8);
		chk(16'(seen), 16'h00AB);
		chk(16'(lastLen[7]), 16'h0003);
		chk(16'(rv), 16'h0000);
		chk(16'(noiseHighThreshold), 16'h0000);
		chk(16'(timingSweepRate), 16'h0000);
		chk(16'(frontendIqSwap), 16'h0000);
		chk(16'(deviceEnabled), 16'h0001);
		chk(16'(acquisitionRun), 16'h0000);
		u_host.rd(REG_BLOCK_RESET, v);
		chk(16'(v), 16'h0000);
		u_host.rd(REG_DEVICE_SETUP, v);
		chk(16'(v), 16'h0088);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		tick(1);
		chk(16'(deviceEnabled), 16'h0000);
		u_host.rd(REG_DEVICE_SETUP, v);
		chk(16'(v), 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
